// >>> rtl/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// ==================================================
// Register locations
`define CCR_ADDR_CTRL 8'h01
`define CCR_ADDR_VBAT 8'h02
`define CCR_ADDR_CUR 8'h03
// ==================================================
// Reset values
`define CCR_RST_CTRL 7'h0C
`define CCR_RST_VBAT 8'h8F
`define CCR_RST_CUR 8'hF8
`define CCR_UNMAPPED_READ 8'hFF
// ==================================================
// Field positions in the control register
`define CCR_RESET_BIT 7
`define CCR_LIMIT_HI 6
`define CCR_LIMIT_LO 4
`define CCR_STAT_EN_BIT 3
`define CCR_TERM_EN_BIT 2
`define CCR_CHG_DIS_BIT 1
`define CCR_STANDBY_BIT 0
// ==================================================
// Field positions in the voltage and current registers
`define CCR_VBAT_HI 7
`define CCR_VBAT_LO 2
`define CCR_CHARGE_CURRENT_SETTING_HI 7
`define CCR_CHARGE_CURRENT_SETTING_LO 3
`define CCR_TERMINATION_CURRENT_THRESHOLD_HI 2
`define CCR_TERMINATION_CURRENT_THRESHOLD_LO 0
// ==================================================
// Codes
`define CCR_CHARGE_CURRENT_SETTING_EXT 5'h1F
`define CCR_LIMIT_EXT 3'h6
`define CCR_STATUS_BUSY 2'h1
`define CCR_STATUS_DONE 2'h2
`define CCR_STATUS_FAULT 2'h3
`define CCR_BYTE_BITS 4'h8
`endif

// >>> rtl/ccr_pkg.sv
package ccr_pkg;
  // ==================================================
  // Serial slave states
  typedef enum logic [3:0] {
    CCR_IDLE  = 4'b0000,
    CCR_ADDR  = 4'b0001,
    CCR_ACK_A = 4'b0010,
    CCR_REG   = 4'b0011,
    CCR_ACK_R = 4'b0100,
    CCR_WDATA = 4'b0101,
    CCR_ACK_W = 4'b0110,
    CCR_RDATA = 4'b0111,
    CCR_MACK  = 4'b1000
  } ccr_state_t;

  // ==================================================
  // One register write from the serial slave
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ccr_wr_t;

  // ==================================================
  // Settings handed to the charger core
  typedef struct packed {
    logic host_mode;
    logic [2:0] input_current_limit;
    logic use_input_limit_resistor;
    logic term_enable;
    logic regulator_enable;
    logic battery_switch_on;
    logic charge_enable;
    logic [5:0] battery_regulation_voltage;
    logic [4:0] charge_current_setting;
    logic use_charge_current_resistor;
    logic [2:0] termination_current_threshold;
    logic term_tenth_of_charge;
  } ccr_ctrl_t;
endpackage : ccr_pkg

// >>> rtl/ccr_charger_control_registers.sv
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_charger_control_registers #(
  parameter logic [6:0] DEV_ADDR = 7'h6A,
  parameter bit DETECT_SOURCE = 1'b1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wd_expired,
  input wire logic input_valid,
  input wire logic [1:0] source_detect_result,
  input wire logic [1:0] source_select_pins,
  input wire logic [1:0] charge_status,
  output ccr_pkg::ccr_ctrl_t ctrl,
  output logic [1:0] reported_status,
  output logic stat_out,
  output logic stat_oe
);

  // ==================================================
  // Pin synchronisers
  // Bus lines idle high, so they reset high and give no false edge
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic [1:0] pins_s1_ff, pins_s2_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      pins_s1_ff <= 2'h0;
      pins_s2_ff <= 2'h0;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
      pins_s1_ff <= source_select_pins;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // START and STOP need SCL high on both samples, so data that moves
  // while SCL is low is never taken for one
  wire scl_rise = scl_s2_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s2_ff & scl_d_ff;
  wire bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  wire bus_stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

  // ==================================================
  // Register storage
  // Only the voltage field is stored; the low bits of the byte are read-only
  localparam logic [7:0] VBAT_RESET = `CCR_RST_VBAT;
  logic [6:0] ctrl_reg_ff;
  logic [5:0] vbat_reg_ff;
  logic [7:0] cur_reg_ff;
  logic host_mode_ff;
  ccr_pkg::ccr_wr_t wr;

  // Read-only source field: detection result or synchronised select pins
  wire [1:0] source_field = DETECT_SOURCE ? source_detect_result : pins_s2_ff;

  // ==================================================
  // Read data selection
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] val;
    val = `CCR_UNMAPPED_READ;
    if (addr == `CCR_ADDR_CTRL) begin
      val = {1'b0, ctrl_reg_ff};
    end else if (addr == `CCR_ADDR_VBAT) begin
      val = {vbat_reg_ff, source_field};
    end else if (addr == `CCR_ADDR_CUR) begin
      val = cur_reg_ff;
    end
    return val;
  endfunction : read_byte

  // ==================================================
  // Register writes
  wire wr_ctrl = wr.valid && (wr.addr == `CCR_ADDR_CTRL);
  wire wr_vbat = wr.valid && (wr.addr == `CCR_ADDR_VBAT);
  wire wr_cur = wr.valid && (wr.addr == `CCR_ADDR_CUR);
  wire soft_reset = wr_ctrl && wr.data[`CCR_RESET_BIT];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg_ff <= `CCR_RST_CTRL;
      vbat_reg_ff <= VBAT_RESET[`CCR_VBAT_HI:`CCR_VBAT_LO];
      cur_reg_ff <= `CCR_RST_CUR;
    end else if (soft_reset) begin
      // The other bits of a reset byte are dropped
      ctrl_reg_ff <= `CCR_RST_CTRL;
      vbat_reg_ff <= VBAT_RESET[`CCR_VBAT_HI:`CCR_VBAT_LO];
      cur_reg_ff <= `CCR_RST_CUR;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg_ff <= wr.data[6:0];
      end
      if (wr_vbat) begin
        vbat_reg_ff <= wr.data[`CCR_VBAT_HI:`CCR_VBAT_LO];
      end
      if (wr_cur) begin
        cur_reg_ff <= wr.data;
      end
    end
  end

  // ==================================================
  // Host mode
  // A write in the same cycle as watchdog expiry keeps host mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      host_mode_ff <= 1'b0;
    end else if (wr.valid) begin
      host_mode_ff <= 1'b1;
    end else if (wd_expired) begin
      host_mode_ff <= 1'b0;
    end
  end

  // ==================================================
  // Serial slave
  ccr_pkg::ccr_state_t state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] ptr_ff, nxt_ptr;
  logic rw_ff, nxt_rw;
  logic nack_ff, nxt_nack;
  ccr_pkg::ccr_wr_t nxt_wr;

  wire byte_done = (bit_cnt_ff == `CCR_BYTE_BITS);

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_wr = '0;
    if (bus_start) begin
      nxt_state = ccr_pkg::CCR_ADDR;
      nxt_bit_cnt = 4'h0;
    end else if (bus_stop) begin
      nxt_state = ccr_pkg::CCR_IDLE;
    end else begin
      if (scl_rise) begin
        nxt_shift = {shift_ff[6:0], sda_s2_ff};
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
        if (state_ff == ccr_pkg::CCR_MACK) begin
          nxt_nack = sda_s2_ff;
        end
      end
      if (scl_fall) begin
        case (state_ff)
          ccr_pkg::CCR_ADDR: begin
            if (byte_done) begin
              nxt_rw = shift_ff[0];
              nxt_state = (shift_ff[7:1] == DEV_ADDR) ? ccr_pkg::CCR_ACK_A
                                                      : ccr_pkg::CCR_IDLE;
            end
          end
          ccr_pkg::CCR_ACK_A: begin
            // Fetch at the ack fall so bit 7 stands through the whole low phase
            nxt_bit_cnt = 4'h0;
            if (rw_ff) begin
              nxt_tx = read_byte(ptr_ff);
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ccr_pkg::CCR_RDATA;
            end else begin
              nxt_state = ccr_pkg::CCR_REG;
            end
          end
          ccr_pkg::CCR_REG: begin
            if (byte_done) begin
              nxt_ptr = shift_ff;
              nxt_state = ccr_pkg::CCR_ACK_R;
            end
          end
          ccr_pkg::CCR_ACK_R: begin
            nxt_bit_cnt = 4'h0;
            nxt_state = ccr_pkg::CCR_WDATA;
          end
          ccr_pkg::CCR_WDATA: begin
            if (byte_done) begin
              nxt_wr.valid = 1'b1;
              nxt_wr.addr = ptr_ff;
              nxt_wr.data = shift_ff;
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ccr_pkg::CCR_ACK_W;
            end
          end
          ccr_pkg::CCR_ACK_W: begin
            nxt_bit_cnt = 4'h0;
            nxt_state = ccr_pkg::CCR_WDATA;
          end
          ccr_pkg::CCR_RDATA: begin
            if (byte_done) begin
              nxt_state = ccr_pkg::CCR_MACK;
            end else begin
              nxt_tx = {tx_ff[6:0], 1'b1};
            end
          end
          ccr_pkg::CCR_MACK: begin
            // A master NACK ends the read; an ACK fetches the next byte
            nxt_bit_cnt = 4'h0;
            if (nack_ff) begin
              nxt_state = ccr_pkg::CCR_IDLE;
            end else begin
              nxt_tx = read_byte(ptr_ff);
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ccr_pkg::CCR_RDATA;
            end
          end
          default: begin
            nxt_state = ccr_pkg::CCR_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ccr_pkg::CCR_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'hFF;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      wr <= '0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      tx_ff <= nxt_tx;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      wr <= nxt_wr;
    end
  end

  // ==================================================
  // Data line: open drain, a one is sent by releasing the line
  wire in_ack = (state_ff == ccr_pkg::CCR_ACK_A) || (state_ff == ccr_pkg::CCR_ACK_R)
             || (state_ff == ccr_pkg::CCR_ACK_W);
  wire send_zero = (state_ff == ccr_pkg::CCR_RDATA) && !tx_ff[7];

  assign sda_out = 1'b0;
  assign sda_oe = in_ack || send_zero;

  // ==================================================
  // Charger settings
  wire stat_en = ctrl_reg_ff[`CCR_STAT_EN_BIT];
  wire term_en = ctrl_reg_ff[`CCR_TERM_EN_BIT];
  wire chg_dis = ctrl_reg_ff[`CCR_CHG_DIS_BIT];
  wire standby = ctrl_reg_ff[`CCR_STANDBY_BIT];
  wire [2:0] limit_code = ctrl_reg_ff[`CCR_LIMIT_HI:`CCR_LIMIT_LO];
  wire [4:0] charge_current_setting_code = cur_reg_ff[`CCR_CHARGE_CURRENT_SETTING_HI:`CCR_CHARGE_CURRENT_SETTING_LO];
  wire charge_current_setting_ext = (charge_current_setting_code == `CCR_CHARGE_CURRENT_SETTING_EXT);

  ccr_pkg::ccr_ctrl_t nxt_ctrl;
  logic [1:0] nxt_status;

  always_comb begin
    nxt_ctrl.host_mode = host_mode_ff;
    nxt_ctrl.input_current_limit = limit_code;
    nxt_ctrl.use_input_limit_resistor = !host_mode_ff || (limit_code == `CCR_LIMIT_EXT);
    nxt_ctrl.term_enable = term_en;
    nxt_ctrl.regulator_enable = !standby;
    nxt_ctrl.battery_switch_on = standby || !(chg_dis && input_valid);
    nxt_ctrl.charge_enable = !chg_dis && !standby;
    nxt_ctrl.battery_regulation_voltage = vbat_reg_ff;
    nxt_ctrl.charge_current_setting = charge_current_setting_code;
    nxt_ctrl.use_charge_current_resistor = charge_current_setting_ext;
    nxt_ctrl.termination_current_threshold = cur_reg_ff[`CCR_TERMINATION_CURRENT_THRESHOLD_HI:`CCR_TERMINATION_CURRENT_THRESHOLD_LO];
    nxt_ctrl.term_tenth_of_charge = charge_current_setting_ext;
    // Without termination a finished charge is reported as still charging
    nxt_status = charge_status;
    if (!term_en && (charge_status == `CCR_STATUS_DONE)) begin
      nxt_status = `CCR_STATUS_BUSY;
    end
  end

  // ==================================================
  // Registered status outputs
  logic stat_oe_ff;
  wire stat_pull = stat_en && ((nxt_status == `CCR_STATUS_BUSY)
                || (nxt_status == `CCR_STATUS_FAULT));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '0;
      reported_status <= 2'h0;
      stat_oe_ff <= 1'b0;
    end else begin
      ctrl <= nxt_ctrl;
      reported_status <= nxt_status;
      stat_oe_ff <= stat_pull;
    end
  end

  assign stat_out = 1'b0;
  assign stat_oe = stat_oe_ff;

endmodule : ccr_charger_control_registers

// >>> verification/ccr_host_model.sv
`timescale 1ns/1ps
module ccr_host_model #(
  parameter logic [6:0] DEV = 7'h6A
) (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ==========
  // Bus phases, each above the 4-cycle minimum
  localparam int PH = 5;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (PH) @(negedge mclk);
  endtask : half
  task automatic start();
    @(negedge mclk);
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge mclk);
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // Eight bits and the ninth clock; data moves one cycle after the falling clock
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      @(negedge mclk);
      sda_low = !v[i];
      half();
      scl = 1'b1;
      half();
      r[i] = sda;
      scl = 1'b0;
    end
  endtask : xfer
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, output int acks);
    logic [8:0] r;
    acks = 0;
    start();
    for (int k = 0; k < 3; k++) begin
      xfer({(k == 0) ? {DEV, 1'b0} : (k == 1) ? a : d, 1'b1}, r);
      acks += int'(!r[0]);
    end
    stop();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d, output int acks);
    logic [8:0] r;
    acks = 0;
    start();
    xfer({DEV, 1'b0, 1'b1}, r);
    acks += int'(!r[0]);
    xfer({a, 1'b1}, r);
    acks += int'(!r[0]);
    start();
    xfer({DEV, 1'b1, 1'b1}, r);
    acks += int'(!r[0]);
    xfer(9'h1FF, r);
    d = r[8:1];
    stop();
  endtask : reg_rd
endmodule : ccr_host_model

// >>> verification/ccr_charger_control_registers_props.sv
`timescale 1ns/1ps
module ccr_charger_control_registers_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sda_out,
  input wire logic wd_expired,
  input wire logic input_valid,
  input wire logic [1:0] charge_status,
  input wire ccr_pkg::ccr_ctrl_t ctrl,
  input wire logic [1:0] reported_status,
  input wire logic stat_out,
  input wire logic stat_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========
  // Properties
  property p_lim;
    $past(nrst) |->
      ctrl.use_input_limit_resistor == (!ctrl.host_mode || ctrl.input_current_limit == 3'h6);
  endproperty
  a_lim: assert property (p_lim) else $error("input limit source wrong");
  property p_wd;
    wd_expired |-> ##2 !ctrl.host_mode;
  endproperty
  a_wd: assert property (p_wd) else $error("host mode kept after expiry");
  property p_stat;
    stat_oe |-> reported_status[0] || $past(reported_status[0]);
  endproperty
  a_stat: assert property (p_stat) else $error("status pin pulled wrongly");
  property p_od;
    !sda_out && !stat_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain output driven high");
  property p_hide;
    !ctrl.term_enable && !$past(ctrl.term_enable) |-> reported_status != 2'h2;
  endproperty
  a_hide: assert property (p_hide) else $error("termination reported");
  property p_rep;
    $past(nrst) && ctrl.term_enable && $past(ctrl.term_enable) |->
      reported_status == $past(charge_status);
  endproperty
  a_rep: assert property (p_rep) else $error("status not passed through");
  property p_dis;
    ctrl.regulator_enable && !ctrl.charge_enable && $past(input_valid) |->
      !ctrl.battery_switch_on;
  endproperty
  a_dis: assert property (p_dis) else $error("battery switch not opened");
  property p_noin;
    ctrl.regulator_enable && !$past(input_valid) |-> ctrl.battery_switch_on;
  endproperty
  a_noin: assert property (p_noin) else $error("battery switch opened");
  property p_hz;
    $past(nrst) && !ctrl.regulator_enable |-> ctrl.battery_switch_on && !ctrl.charge_enable;
  endproperty
  a_hz: assert property (p_hz) else $error("standby switch state wrong");
  property p_ext;
    (ctrl.use_charge_current_resistor == (ctrl.charge_current_setting == 5'h1F)) &&
      (ctrl.term_tenth_of_charge == ctrl.use_charge_current_resistor);
  endproperty
  a_ext: assert property (p_ext) else $error("charge resistor select wrong");
  property p_def;
    $past(nrst) && !$past(nrst, 2) |-> ctrl.battery_regulation_voltage == 6'h23 &&
      ctrl.charge_current_setting == 5'h1F && !ctrl.host_mode;
  endproperty
  a_def: assert property (p_def) else $error("reset settings wrong");
  c_host: cover property (ctrl.host_mode);
  c_hide: cover property (!ctrl.term_enable && reported_status == 2'h1);
  c_stat: cover property (stat_oe);
endmodule : ccr_charger_control_registers_props
bind ccr_charger_control_registers ccr_charger_control_registers_props ccr_props_i (
  .mclk, .nrst, .sda_out, .wd_expired, .input_valid, .charge_status, .ctrl,
  .reported_status, .stat_out, .stat_oe
);

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wd_expired = 1'b0;
  logic input_valid = 1'b1;
  logic [1:0] source_detect_result = 2'h3;
  logic [1:0] source_select_pins = 2'h0;
  logic [1:0] charge_status = 2'h0;
  logic scl, sda_low, sda_out, sda_oe, stat_out, stat_oe;
  logic [1:0] reported_status;
  ccr_pkg::ccr_ctrl_t ctrl;
  // Pull-up on the data line
  wire logic sda = !(sda_low || sda_oe);
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int acks;
  logic [7:0] rd;
  always #12.5 mclk = ~mclk;
  ccr_charger_control_registers ccr_charger_control_registers_i (
    .mclk, .nrst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .wd_expired,
    .input_valid, .source_detect_result, .source_select_pins, .charge_status,
    .ctrl, .reported_status, .stat_out, .stat_oe
  );
  ccr_host_model ccr_host_model_i (.mclk, .sda, .scl, .sda_low);
  // ==========
  // Helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ccr_host_model_i.reg_wr(a, d, acks);
    chk("write acks", 8'h03, 8'(acks));
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    ccr_host_model_i.reg_rd(a, rd, acks);
    chk("read acks", 8'h03, 8'(acks));
    chk("read data", e, rd);
  endtask : rdc
  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask : settle
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // ==========
  // Scenarios
  task automatic t_reset();
    rdc(8'h02, 8'h8F);
    rdc(8'h03, 8'hF8);
    rdc(8'h01, 8'h0C);
    rdc(8'h00, 8'hFF);
    chk("host", 8'h00, 8'(ctrl.host_mode));
    chk("lim res", 8'h01, 8'(ctrl.use_input_limit_resistor));
  endtask : t_reset
  task automatic t_source();
    for (int c = 0; c < 4; c++) begin
      source_detect_result = 2'(c);
      rdc(8'h02, {6'h23, 2'(c)});
    end
    wr(8'h02, 8'hA4);
    rdc(8'h02, 8'hA7);
    chk("vbat", 8'h29, 8'(ctrl.battery_regulation_voltage));
    chk("host", 8'h01, 8'(ctrl.host_mode));
  endtask : t_source
  task automatic t_current();
    wr(8'h03, 8'h42);
    chk("charge_current_setting", 8'h08, 8'(ctrl.charge_current_setting));
    chk("termination_current_threshold", 8'h02, 8'(ctrl.termination_current_threshold));
    wr(8'h03, 8'hF0);
    chk("charge_current_setting res", 8'h00, 8'(ctrl.use_charge_current_resistor));
    wr(8'h03, 8'hFD);
    chk("charge_current_setting res", 8'h01, 8'(ctrl.use_charge_current_resistor));
    chk("tenth", 8'h01, 8'(ctrl.term_tenth_of_charge));
    rdc(8'h03, 8'hFD);
  endtask : t_current
  task automatic t_ctrl();
    wr(8'h01, 8'h6E);
    chk("limit", 8'h06, 8'(ctrl.input_current_limit));
    chk("lim res", 8'h01, 8'(ctrl.use_input_limit_resistor));
    chk("bat sw", 8'h00, 8'(ctrl.battery_switch_on));
    chk("regulator", 8'h01, 8'(ctrl.regulator_enable));
    chk("chg en", 8'h00, 8'(ctrl.charge_enable));
    input_valid = 1'b0;
    settle();
    chk("bat sw", 8'h01, 8'(ctrl.battery_switch_on));
    input_valid = 1'b1;
    charge_status = 2'h2;
    wr(8'h01, 8'h71);
    rdc(8'h01, 8'h71);
    chk("term en", 8'h00, 8'(ctrl.term_enable));
    chk("regulator", 8'h00, 8'(ctrl.regulator_enable));
    chk("bat sw", 8'h01, 8'(ctrl.battery_switch_on));
    chk("lim res", 8'h00, 8'(ctrl.use_input_limit_resistor));
    chk("status", 8'h01, 8'(reported_status));
    chk("stat oe", 8'h00, 8'(stat_oe));
    wr(8'h01, 8'h0C);
    chk("status", 8'h02, 8'(reported_status));
    charge_status = 2'h3;
    settle();
    chk("stat oe", 8'h01, 8'(stat_oe));
  endtask : t_ctrl
  task automatic t_wd();
    wd_expired = 1'b1;
    @(negedge mclk);
    wd_expired = 1'b0;
    settle();
    chk("host", 8'h00, 8'(ctrl.host_mode));
    chk("lim res", 8'h01, 8'(ctrl.use_input_limit_resistor));
  endtask : t_wd
  task automatic t_soft();
    wr(8'h01, 8'hF1);
    rdc(8'h02, 8'h8F);
    rdc(8'h03, 8'hF8);
    rdc(8'h01, 8'h0C);
  endtask : t_soft
  // ==========
  // Main sequence and hang guard
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_source();
    t_current();
    t_ctrl();
    t_wd();
    t_soft();
    end_sim();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      end_sim();
    end
  end
endmodule : testbench
